// File: spifs_pkg.sv
// Purpose: Shared constants and types of the SPI FIFO, status and interrupt block.
// Assumes: APB with 32-bit data and 12-bit byte addresses.
// Notes:   Offsets are byte addresses of aligned words.
package spifs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned LVL_W      = 4;
  localparam int unsigned IRQ_W      = 4;
  localparam int unsigned TO_W       = 6;
  localparam int unsigned HALF_W     = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  localparam logic [11:0] OFS_IE   = 12'h010;
  localparam logic [11:0] OFS_RIS  = 12'h014;
  localparam logic [11:0] OFS_IC   = 12'h018;
  localparam logic [11:0] OFS_DATA = 12'h01c;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_ROLE_BIT = 3;
  localparam int unsigned CTRL_LEN_LSB  = 8;
  localparam int unsigned CTRL_LEN_MSB  = 11;
  localparam int unsigned CTRL_TXTH_LSB = 12;
  localparam int unsigned CTRL_TXTH_MSB = 14;
  localparam int unsigned CTRL_RXTH_LSB = 15;
  localparam int unsigned CTRL_RXTH_MSB = 17;
  localparam logic [3:0]  LEN_FIELD_RST = 4'hf;
  localparam logic [3:0]  LEN_FIELD_MIN = 4'h2;

  // ----------------------------------------------------------------
  // Status and interrupt bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_TXE_BIT  = 0;
  localparam int unsigned ST_TXF_BIT  = 1;
  localparam int unsigned ST_RXE_BIT  = 2;
  localparam int unsigned ST_RXF_BIT  = 3;
  localparam int unsigned ST_BUSY_BIT = 4;
  localparam int unsigned ST_TXTH_BIT = 5;
  localparam int unsigned ST_RXTH_BIT = 6;
  localparam int unsigned IRQ_OVR_BIT  = 0;
  localparam int unsigned IRQ_TO_BIT   = 1;
  localparam int unsigned IRQ_RXTH_BIT = 2;
  localparam int unsigned IRQ_TXTH_BIT = 3;

  // Receive time-out in peripheral clock cycles
  localparam logic [TO_W-1:0] RX_TO_CYC = 6'h20;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_MLOW  = 4'b0010,
    ST_MHIGH = 4'b0100,
    ST_SACT  = 4'b1000
  } spifs_state_t;

endpackage

// File: spifs_fifo_if.sv
// Purpose: Bundle between the block and one of its FIFOs.
// Assumes: One owner drives push and pop, the FIFO answers.
// Notes:   Push while full and not popping overwrites the newest entry.
`timescale 1ns/100ps
interface spifs_fifo_if #(
  parameter int unsigned W = 16
);
  logic         push;
  logic         pop;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic         full;
  logic         empty;
  logic [3:0]   level;

  modport user  (output push, pop, wdata, input rdata, full, empty, level);
  modport store (input push, pop, wdata, output rdata, full, empty, level);
endinterface

// File: spifs_fifo.sv
// Purpose: Small FIFO with registered head-of-queue output.
// Assumes: DEPTH is a power of two below 16.
// Notes:   rdata always shows the oldest entry, including one just pushed.
`timescale 1ns/100ps
module spifs_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Queue side
  spifs_fifo_if.store     f
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [3:0]    level_r;
  logic [W-1:0]  rdata_r;

  wire           do_pop   = f.pop & ~f.empty;
  wire           ovw      = f.push & f.full & ~do_pop;
  wire           do_push  = f.push & ~ovw;
  // Overwrite lands on the newest entry so older frames stay intact
  wire [PW-1:0]  wr_addr  = ovw ? wr_ptr_r - 1'b1 : wr_ptr_r;
  wire [PW-1:0]  rd_nxt   = do_pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  wire           bypass   = f.push & (wr_addr == rd_nxt);

  assign f.full  = level_r == 4'(DEPTH);
  assign f.empty = level_r == 4'h0;
  assign f.level = level_r;
  assign f.rdata = rdata_r;

  always_ff @(posedge pclk) begin
    if (f.push) begin
      mem[wr_addr] <= f.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= 4'h0;
      rdata_r  <= '0;
    end else begin
      wr_ptr_r <= do_push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= rd_nxt;
      level_r  <= level_r + {3'h0, do_push} - {3'h0, do_pop};
      rdata_r  <= bypass ? f.wdata : mem[rd_nxt];
    end
  end
endmodule

// File: spifs_top.sv
// Purpose: SPI FIFO status, interrupt and data port with a basic shift engine.
// Assumes: Mode 0, MSB first; link pins come from outside the pclk domain.
// Notes:   APB answers with no wait states; read data is captured in setup.
// Summary of operation
// R1 - Receive level flag high while receive FIFO holds more than its threshold.
// R2 - Transmit level flag high while transmit FIFO holds threshold or fewer.
// R3 - Busy bit reads one during a frame, zero when idle.
// R4 - Receive full on status bit 3, receive empty on bit 2.
// R5 - Transmit full on status bit 1, transmit empty on bit 0.
// R6 - Master starts shifting automatically whenever transmit FIFO is not empty.
// R7 - Four enable bits: tx level, rx level, time-out, overrun, reset zero.
// R8 - Raw bits record events always; request only when raw and enable set.
// R9 - Threshold events set their raw bits, which reset to zero.
// R10 - Time-out raw bit sets after 32 cycles unread with data waiting.
// R11 - Frame arriving while receive FIFO full sets overrun and overwrites.
// R12 - Writing one to a clear bit clears the raw bit; zero does nothing.
// R13 - Software writes a frame only while transmit FIFO is not full.
// R14 - Written frame starts at once if idle, else after earlier frames.
// R15 - Data read returns and removes the oldest received frame.
// R16 - Short frames are right-justified with zero upper bits.
// R17 - Two 3-bit threshold fields, levels 0 to 7, reset zero.
// R18 - Frame length is field plus one, 3 to 16, reset 16.
// R19 - Role select zero means master, one means slave.
// R20 - Each FIFO holds eight 16-bit entries.
// R21 - Threshold raw bits latch on the flag's rising edge until cleared.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module spifs_top
  import spifs_pkg::*;
#(
  parameter int unsigned SCK_HALF = 4
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt request
  output logic             spi_irq,
  // Serial clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  // Select pin, active low
  input  wire logic        sel_n_i,
  output logic             sel_n_o,
  output logic             sel_n_oe,
  // Data pins
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe
);

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  spifs_fifo_if #(.W(DATA_W)) tx_f ();
  spifs_fifo_if #(.W(DATA_W)) rx_f ();

  spifs_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo ( // see R20
    .pclk    (pclk),
    .presetn (presetn),
    .f       (tx_f)
  );
  spifs_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (rx_f)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic       sck_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Clock bit resets to its idle low level so no false edge follows reset
      pin_meta_r <= 4'he;
      pin_sync_r <= 4'he;
      sck_d_r    <= 1'b0;
    end else begin
      pin_meta_r <= {miso_i, mosi_i, sel_n_i, sck_i};
      pin_sync_r <= pin_meta_r;
      sck_d_r    <= pin_sync_r[0];
    end
  end

  wire sck_s    = pin_sync_r[0];
  wire sel_n_s  = pin_sync_r[1];
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                 ctrl_en_r;
  logic                 role_select_r;
  logic [3:0]           frame_length_field_r;
  logic [2:0]           tx_level_setting_r;
  logic [2:0]           rx_level_setting_r;
  logic [IRQ_W-1:0]     irq_en_r;
  logic [IRQ_W-1:0]     irq_raw_r;
  logic [IRQ_W-1:0]     irq_raw_nxt;
  logic [31:0]          prdata_r;
  logic [31:0]          ctrl_word;
  logic [31:0]          stat_word;

  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire rd_acc   = psel & penable & ~pwrite;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_stat = paddr == OFS_STAT;
  wire hit_ie   = paddr == OFS_IE;
  wire hit_ris  = paddr == OFS_RIS;
  wire hit_ic   = paddr == OFS_IC;
  wire hit_data = paddr == OFS_DATA;
  wire addr_ok  = hit_ctrl | hit_stat | hit_ie | hit_ris | hit_ic | hit_data;

  // Writes to a full queue are dropped rather than overwriting data
  wire tx_push  = wr_acc & hit_data & ~tx_f.full; // see R13
  wire rx_pop   = rd_acc & hit_data & ~rx_f.empty; // see R15

  // Stored length field codes 0 and 1 behave as the shortest frame
  wire [3:0] idx_start = (frame_length_field_r < LEN_FIELD_MIN) ?
                         LEN_FIELD_MIN : frame_length_field_r; // see R18

  wire tx_level_low_flag   = tx_f.level <= {1'b0, tx_level_setting_r}; // see R2
  wire rx_level_above_flag = rx_f.level > {1'b0, rx_level_setting_r}; // see R1
  wire busy;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_EN_BIT] = ctrl_en_r;
    ctrl_word[CTRL_ROLE_BIT] = role_select_r;
    ctrl_word[CTRL_LEN_MSB:CTRL_LEN_LSB] = frame_length_field_r;
    ctrl_word[CTRL_TXTH_MSB:CTRL_TXTH_LSB] = tx_level_setting_r;
    ctrl_word[CTRL_RXTH_MSB:CTRL_RXTH_LSB] = rx_level_setting_r;
    stat_word = 32'h0000_0000;
    stat_word[ST_TXE_BIT] = tx_f.empty; // see R5
    stat_word[ST_TXF_BIT] = tx_f.full;
    stat_word[ST_RXE_BIT] = rx_f.empty; // see R4
    stat_word[ST_RXF_BIT] = rx_f.full;
    stat_word[ST_BUSY_BIT] = busy; // see R3
    stat_word[ST_TXTH_BIT] = tx_level_low_flag;
    stat_word[ST_RXTH_BIT] = rx_level_above_flag;
  end

  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_stat ? stat_word :
                       hit_ie   ? {28'h000_0000, irq_en_r} :
                       hit_ris  ? {28'h000_0000, irq_raw_r} :
                       hit_data ? {16'h0000, rx_f.rdata} : 32'h0000_0000;

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign spi_irq = |(irq_raw_r & irq_en_r); // see R8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r            <= 1'b0;
      role_select_r        <= 1'b0;
      frame_length_field_r <= LEN_FIELD_RST;
      tx_level_setting_r   <= 3'h0;
      rx_level_setting_r   <= 3'h0;
      irq_en_r             <= 4'h0;
      prdata_r             <= 32'h0000_0000;
    end else begin
      if (setup) begin
        prdata_r <= rd_mux;
      end
      if (wr_acc & hit_ctrl) begin
        ctrl_en_r            <= pwdata[CTRL_EN_BIT];
        role_select_r        <= pwdata[CTRL_ROLE_BIT]; // see R19
        frame_length_field_r <= pwdata[CTRL_LEN_MSB:CTRL_LEN_LSB];
        tx_level_setting_r   <= pwdata[CTRL_TXTH_MSB:CTRL_TXTH_LSB]; // see R17
        rx_level_setting_r   <= pwdata[CTRL_RXTH_MSB:CTRL_RXTH_LSB];
      end
      if (wr_acc & hit_ie) begin
        irq_en_r <= pwdata[IRQ_W-1:0]; // see R7
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  spifs_state_t       state_r;
  logic [DATA_W-1:0]  tx_word_r;
  logic [DATA_W-1:0]  rx_sh_r;
  logic [3:0]         bit_idx_r;
  logic [HALF_W-1:0]  half_cnt_r;
  logic               reload_r;
  logic               sck_r;
  logic               mosi_r;
  logic               miso_r;
  logic               sel_n_r;

  function automatic logic [DATA_W-1:0] len_mask(input logic [3:0] top);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = (i <= int'(top));
    end
    return m;
  endfunction

  wire half_done  = half_cnt_r == HALF_W'(SCK_HALF - 1);
  wire start_m    = ctrl_en_r & ~role_select_r & ~tx_f.empty; // see R6
  wire start_s    = ctrl_en_r & role_select_r & ~sel_n_s;
  wire in_idle    = state_r == ST_IDLE;
  wire in_sact    = state_r == ST_SACT;
  wire sample_pt  = ((state_r == ST_MHIGH) & half_done) | (in_sact & sck_rise & ~sel_n_s);
  wire bit_in     = role_select_r ? pin_sync_r[2] : pin_sync_r[3];
  wire frame_end  = sample_pt & (bit_idx_r == 4'h0);
  wire slv_reload = in_sact & sck_fall & reload_r & ~sel_n_s;
  // An empty queue in slave role sends zeros
  wire [DATA_W-1:0] tx_load = tx_f.empty ? '0 : tx_f.rdata;
  wire [DATA_W-1:0] rx_word = {rx_sh_r[DATA_W-2:0], bit_in} & len_mask(idx_start); // see R16

  assign busy       = ~in_idle;
  assign tx_f.push  = tx_push;
  assign tx_f.wdata = pwdata[DATA_W-1:0];
  assign tx_f.pop   = (in_idle & (start_m | start_s)) | slv_reload; // see R14
  assign rx_f.push  = frame_end;
  assign rx_f.wdata = rx_word;
  assign rx_f.pop   = rx_pop;

  assign sck_o    = sck_r;
  assign mosi_o   = mosi_r;
  assign miso_o   = miso_r;
  assign sel_n_o  = sel_n_r;
  assign sck_oe   = ctrl_en_r & ~role_select_r;
  assign mosi_oe  = ctrl_en_r & ~role_select_r;
  assign sel_n_oe = ctrl_en_r & ~role_select_r;
  assign miso_oe  = ctrl_en_r & role_select_r & ~sel_n_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_IDLE;
      tx_word_r  <= '0;
      rx_sh_r    <= '0;
      bit_idx_r  <= 4'h0;
      half_cnt_r <= '0;
      reload_r   <= 1'b0;
      sck_r      <= 1'b0;
      mosi_r     <= 1'b0;
      miso_r     <= 1'b0;
      sel_n_r    <= 1'b1;
    end else begin
      half_cnt_r <= half_done ? '0 : half_cnt_r + 1'b1;
      if (sample_pt) begin
        rx_sh_r   <= rx_word;
        bit_idx_r <= (bit_idx_r == 4'h0) ? bit_idx_r : bit_idx_r - 4'h1;
      end
      unique case (state_r)
        ST_IDLE: begin
          half_cnt_r <= '0;
          if (start_m | start_s) begin
            tx_word_r <= tx_load;
            bit_idx_r <= idx_start;
            mosi_r    <= tx_load[idx_start];
            miso_r    <= tx_load[idx_start];
            sel_n_r   <= ~start_m;
            reload_r  <= 1'b0;
            state_r   <= start_m ? ST_MLOW : ST_SACT;
          end
        end
        ST_MLOW: begin
          if (half_done) begin
            sck_r   <= 1'b1;
            state_r <= ST_MHIGH;
          end
        end
        ST_MHIGH: begin
          if (half_done) begin
            sck_r <= 1'b0;
            if (bit_idx_r == 4'h0) begin
              sel_n_r <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              mosi_r  <= tx_word_r[bit_idx_r - 4'h1];
              state_r <= ST_MLOW;
            end
          end
        end
        ST_SACT: begin
          if (sel_n_s) begin
            state_r <= ST_IDLE;
          end else if (frame_end) begin
            reload_r <= 1'b1;
          end else if (slv_reload) begin
            tx_word_r <= tx_load;
            bit_idx_r <= idx_start;
            miso_r    <= tx_load[idx_start];
            reload_r  <= 1'b0;
          end else if (sck_fall) begin
            miso_r <= tx_word_r[bit_idx_r];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Raw interrupt status
  // ----------------------------------------------------------------
  logic            tx_flag_d_r;
  logic            rx_flag_d_r;
  logic [TO_W-1:0] to_cnt_r;

  wire tx_thr_event     = tx_level_low_flag & ~tx_flag_d_r; // see R21
  wire rx_thr_event     = rx_level_above_flag & ~rx_flag_d_r;
  wire rx_timeout_event = ~rx_f.empty & ~rx_pop & (to_cnt_r == RX_TO_CYC - 6'h01); // see R10
  wire rx_overrun_event = frame_end & rx_f.full & ~rx_pop; // see R11
  wire [IRQ_W-1:0] irq_clr = (wr_acc & hit_ic) ? pwdata[IRQ_W-1:0] : 4'h0;

  always_comb begin
    irq_raw_nxt = irq_raw_r & ~irq_clr; // see R12
    // Setting after clearing lets a same-cycle event survive the clear
    if (tx_thr_event) irq_raw_nxt[IRQ_TXTH_BIT] = 1'b1; // see R9
    if (rx_thr_event) irq_raw_nxt[IRQ_RXTH_BIT] = 1'b1;
    if (rx_timeout_event) irq_raw_nxt[IRQ_TO_BIT] = 1'b1;
    if (rx_overrun_event) irq_raw_nxt[IRQ_OVR_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_raw_r   <= 4'h0;
      tx_flag_d_r <= 1'b1;
      rx_flag_d_r <= 1'b0;
      to_cnt_r    <= '0;
    end else begin
      irq_raw_r   <= irq_raw_nxt;
      tx_flag_d_r <= tx_level_low_flag;
      rx_flag_d_r <= rx_level_above_flag;
      if (rx_f.empty | rx_pop) begin
        to_cnt_r <= '0;
      end else if (to_cnt_r != RX_TO_CYC) begin
        to_cnt_r <= to_cnt_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RX_EMPTY_NO_FLAG: assert property (rx_f.empty |-> !stat_word[ST_RXTH_BIT]) // see R1
    else $error("rx level flag set with empty rx fifo");
  AST_TX_FULL_NO_FLAG: assert property (tx_f.full |-> !stat_word[ST_TXTH_BIT]) // see R2
    else $error("tx level flag set with full tx fifo");
  AST_AUTO_START: assert property (in_idle && start_m |=> busy ##0 !sel_n_o) // see R6
    else $error("master did not start on pending tx data");
  AST_IDLE_BUSY: assert property (in_idle && !start_m && !start_s |=> !stat_word[ST_BUSY_BIT]) // see R3
    else $error("busy set without a frame");
  AST_THR_LATCH: assert property ($rose(rx_level_above_flag) |=> irq_raw_r[IRQ_RXTH_BIT]) // see R21
    else $error("rx threshold raw bit not latched");
  AST_TIMEOUT: assert property ((!rx_f.empty && !rx_pop) [*8] ##0 to_cnt_r == RX_TO_CYC - 6'h01
                                |=> irq_raw_r[IRQ_TO_BIT]) // see R10
    else $error("rx time-out raw bit not set");
  AST_OVERRUN: assert property (rx_f.push && rx_f.full && !rx_pop |=> irq_raw_r[IRQ_OVR_BIT]
                                ##0 rx_f.full) // see R11
    else $error("overrun not flagged");
  AST_CLEAR: assert property (wr_acc && hit_ic && pwdata[IRQ_TO_BIT] && !rx_timeout_event
                              |=> !irq_raw_r[IRQ_TO_BIT]) // see R12
    else $error("time-out raw bit not cleared");
  AST_IRQ_GATE: assert property (rx_overrun_event && irq_en_r == 4'h0 && !(wr_acc && hit_ie)
                                 |=> irq_raw_r[IRQ_OVR_BIT] && !spi_irq) // see R8
    else $error("masked overrun not recorded or request leaked");
  AST_POP: assert property (rx_pop && !rx_f.push |=> rx_f.level == $past(rx_f.level) - 4'h1) // see R15
    else $error("data read did not remove a frame");
  AST_RJUST: assert property (rx_f.push |-> (rx_f.wdata & ~len_mask(idx_start)) == '0) // see R16
    else $error("upper bits of short frame not zero");

  COV_MASTER_FRAME: cover property (state_r == ST_MHIGH && frame_end);
  COV_SLAVE_FRAME: cover property (in_sact && frame_end);
  COV_OVERRUN: cover property (rx_overrun_event);
  COV_TIMEOUT: cover property (rx_timeout_event);
endmodule

// File: spifs_slave_model.sv
// Purpose: Behavioural SPI slave on the far side of the master link.
// Assumes: Mode 0, MSB first, fixed frame length LEN.
// Notes:   Answers each frame with the frame it received before.
`timescale 1ns/100ps
module spifs_slave_model #(
  parameter int LEN = 8
) (
  // Link pins
  input  wire logic sck,
  input  wire logic sel_n,
  input  wire logic mosi,
  output logic      miso
);
  logic [15:0] rx_sh    = 16'h0081;
  logic [15:0] tx_sh    = 16'h0000;
  logic [15:0] last_r   = 16'h0081;
  logic        idle_bit = 1'b0;

  // Deselected: show the inverse of the last bit so stale data cannot pass
  assign miso = sel_n ? idle_bit : tx_sh[LEN-1];
  always @(negedge sel_n) tx_sh = last_r;
  always @(posedge sck) if (!sel_n) rx_sh = {rx_sh[14:0], mosi};
  always @(negedge sck) if (!sel_n) tx_sh = tx_sh << 1;
  always @(posedge sel_n) begin
    last_r   = rx_sh;
    idle_bit = ~tx_sh[LEN-1];
  end
endmodule

// File: test_spifs_top.sv
// Purpose: Self-checking bench of the SPI FIFO, status and interrupt block.
// Assumes: Zero-wait APB slave; 8-bit frames on the link.
// Notes:   Master frames run against the slave model; slave frames are driven here.
`timescale 1ns/100ps
module test_spifs_top;
  import spifs_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic        pready, pslverr, spi_irq, sck_o, sck_oe, sel_n_o, sel_n_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        sck_tb = 1'b0, sel_n_tb = 1'b1, mosi_tb = 1'b0, miso_p, perr, sck_w, sel_w, mosi_w, miso_w;
  logic [7:0]  s;
  logic [7:0]  tx1 [3] = '{8'ha5, 8'h3c, 8'hf0};
  logic [7:0]  ex1 [3] = '{8'h81, 8'ha5, 8'h3c};
  logic [7:0]  ovx [8] = '{8'hf0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h88};
  int          miscompares = 0, num_checks = 0;

  always #4 pclk = ~pclk;
  // Wire level of each link pin from whoever drives it
  assign sck_w  = sck_oe ? sck_o : sck_tb;
  assign sel_w  = sel_n_oe ? sel_n_o : sel_n_tb;
  assign mosi_w = mosi_oe ? mosi_o : mosi_tb;
  assign miso_w = miso_oe ? miso_o : miso_p;

  spifs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .spi_irq, .sck_i(sck_w), .sck_o, .sck_oe, .sel_n_i(sel_w), .sel_n_o, .sel_n_oe, .mosi_i(mosi_w),
    .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe);
  spifs_slave_model #(.LEN(8)) partner (.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .miso(miso_p));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(r & m, e);
  endtask

  // Poll until the transmit queue is empty and no frame is running
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400; k++) begin
      apb(1'b0, OFS_STAT, 32'h0000_0000);
      if ((r & 32'h0000_0011) === 32'h0000_0001) break;
    end
    if (k >= 400) begin
      miscompares++;
      stop_test();
    end
  endtask

  // One 8-bit frame with the bench as master, 80 ns serial clock
  task automatic sframe(input logic [7:0] m);
    @(posedge pclk);
    sel_n_tb <= 1'b0;
    repeat (5) @(posedge pclk);
    for (int i = 7; i >= 0; i--) begin
      mosi_tb <= m[i];
      repeat (5) @(posedge pclk);
      sck_tb <= 1'b1;
      s[i] = miso_o;
      repeat (5) @(posedge pclk);
      sck_tb <= 1'b0;
    end
    repeat (5) @(posedge pclk);
    chk({31'h0, miso_oe}, 32'h0000_0001);
    sel_n_tb <= 1'b1;
    mosi_tb  <= ~m[0];
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cmp(OFS_STAT, 32'hffff_ffff, 32'h0000_0025);
    cmp(OFS_IE, 32'hffff_ffff, 32'h0000_0000);
    cmp(OFS_RIS, 32'hffff_ffff, 32'h0000_0000);
    cmp(OFS_CTRL, 32'hffff_ffff, 32'h0000_0f00);
    apb(1'b1, 12'h040, 32'h0000_ffff);
    chk({31'h0, perr}, 32'h0000_0001);
    cmp(OFS_IC, 32'hffff_ffff, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_8701);
    for (int i = 0; i < 3; i++) apb(1'b1, OFS_DATA, {24'h0, tx1[i]});
    cmp(OFS_STAT, 32'h0000_0010, 32'h0000_0010);
    chk({28'h0, sck_oe, mosi_oe, sel_n_oe, sel_n_o}, 32'h0000_000e);
    wait_idle();
    repeat (40) @(posedge pclk);
    cmp(OFS_STAT, 32'hffff_ffff, 32'h0000_0061);
    cmp(OFS_RIS, 32'hffff_ffff, 32'h0000_000e);
    chk({31'h0, spi_irq}, 32'h0000_0000);
    apb(1'b1, OFS_IE, 32'h0000_0002);
    cmp(OFS_IE, 32'hffff_ffff, 32'h0000_0002);
    chk({31'h0, spi_irq}, 32'h0000_0001);
    apb(1'b1, OFS_IC, 32'h0000_0002);
    cmp(OFS_RIS, 32'hffff_ffff, 32'h0000_000c);
    chk({31'h0, spi_irq}, 32'h0000_0000);
    apb(1'b1, OFS_IC, 32'h0000_000c);
    apb(1'b1, OFS_IE, 32'h0000_0000);
    for (int i = 0; i < 3; i++) cmp(OFS_DATA, 32'hffff_ffff, {24'h0, ex1[i]});
    cmp(OFS_STAT, 32'hffff_ffff, 32'h0000_0025);
    for (int i = 1; i < 10; i++) apb(1'b1, OFS_DATA, 32'h11 * i);
    cmp(OFS_STAT, 32'h0000_0022, 32'h0000_0002);
    wait_idle();
    cmp(OFS_RIS, 32'h0000_0001, 32'h0000_0001);
    cmp(OFS_STAT, 32'h0000_000c, 32'h0000_0008);
    for (int i = 0; i < 8; i++) cmp(OFS_DATA, 32'hffff_ffff, {24'h0, ovx[i]});
    apb(1'b1, OFS_IC, 32'h0000_000f);
    apb(1'b1, OFS_CTRL, 32'h0000_8709);
    apb(1'b1, OFS_DATA, 32'h0000_005a);
    sframe(8'hc3);
    chk({24'h0, s}, 32'h0000_005a);
    cmp(OFS_DATA, 32'hffff_ffff, 32'h0000_00c3);
    stop_test();
  end
endmodule
